// File: hw/lock_bridge_pkg.sv
// Constants and types for the primary-side exclusive access bridge
// Contract
// - Bus lock reaches multifunction pin four only when routing field bits 19-16 selects it.
// - Locks are honoured only downstream, primary to card bus, never forwarded upstream.
// - Non-exclusive transactions still complete while locked if outside the locked block.
// - A bus grant is not lock ownership; ownership follows only the lock handshake.
// - Other initiators keep using the bus while one master holds the lock, tracked per master.
// - A locked region is one naturally aligned 16-byte block; other blocks are not blocked.
// - Write posting stops for the whole duration of a locked operation.
// - The downstream lock is signalled on the card bus lock pin, separate from card clock.
package lock_bridge_pkg;
    localparam int ADDR_W = 32;
    localparam int MASTER_W = 4;
    localparam int ROUTE_W = 4;
    localparam int ROUTE_LSB = 16;
    localparam int ROUTE_MSB = 19;
    localparam logic [ROUTE_W-1:0] ROUTE_LOCK_SEL = 4'h4;
    localparam logic [ROUTE_W-1:0] ROUTE_RESET = 4'h0;
    localparam int LOCK_BLOCK_BITS = 4;
    localparam logic [MASTER_W-1:0] OWNER_RESET = 4'h0;
    localparam logic [ADDR_W-LOCK_BLOCK_BITS-1:0] BLOCK_RESET = 28'h0000000;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_ARMED = 2'b01,
        LK_HELD = 2'b10
    } lock_state_t;

    function automatic logic [ADDR_W-LOCK_BLOCK_BITS-1:0] block_of(
        input logic [ADDR_W-1:0] addr
    );
        block_of = addr[ADDR_W-1:LOCK_BLOCK_BITS];
    endfunction : block_of
endpackage : lock_bridge_pkg

// File: hw/reset_order_sync.sv
// Reset ordering and synchronisation for the primary bus domain
`timescale 1ns/1ps
`default_nettype none
module reset_order_sync (
    // Clock and external resets
    input wire logic clock,
    input wire logic global_reset_n,
    input wire logic primary_bus_reset_n,
    // Synchronised core reset
    output logic core_resetn
);
    logic g1_q;
    logic g2_q;
    logic p1_q;
    logic p2_q;
    logic both_n;

    // Core leaves reset only when both resets are released
    assign both_n = global_reset_n & primary_bus_reset_n;

    always_ff @(posedge clock or negedge both_n) begin
        if (!both_n) begin
            g1_q <= 1'b0;
            g2_q <= 1'b0;
        end else begin
            g1_q <= 1'b1;
            g2_q <= g1_q;
        end
    end

    always_ff @(posedge clock or negedge both_n) begin
        if (!both_n) begin
            p1_q <= 1'b0;
            p2_q <= 1'b0;
        end else begin
            p1_q <= g2_q;
            p2_q <= p1_q;
        end
    end

    assign core_resetn = p2_q;
endmodule : reset_order_sync
`default_nettype wire

// File: hw/lock_bridge.sv
// Primary-side exclusive access tracking and downstream lock forwarding
`timescale 1ns/1ps
`default_nettype none
module lock_bridge (
    // Clock and resets
    input wire logic clock,
    input wire logic resetn,
    input wire logic global_reset_n,
    input wire logic primary_bus_reset_n,
    // Routing control
    input wire logic [lock_bridge_pkg::ROUTE_W-1:0] route_field,
    // Primary bus transaction view
    input wire logic pri_lock_n,
    input wire logic pri_frame_start,
    input wire logic pri_txn_end,
    input wire logic [lock_bridge_pkg::MASTER_W-1:0] pri_master_id,
    input wire logic [lock_bridge_pkg::ADDR_W-1:0] pri_addr,
    input wire logic pri_to_card,
    input wire logic pri_grant,
    // Card bus side
    output logic card_lock_n,
    output logic multifunction_pin_four,
    output logic post_enable,
    output logic txn_retry,
    output logic lock_held,
    output logic [lock_bridge_pkg::MASTER_W-1:0] lock_owner
);
    import lock_bridge_pkg::*;

    logic core_resetn;
    logic lk1_q;
    logic lk2_q;
    lock_state_t state_q;
    logic [MASTER_W-1:0] owner_q;
    logic [ADDR_W-LOCK_BLOCK_BITS-1:0] block_q;
    logic card_lock_n_q;
    logic mf4_q;
    logic post_q;
    logic retry_q;
    logic [ROUTE_W-1:0] route1_q;
    logic [ROUTE_W-1:0] route_q;
    logic held_q;
    logic lock_in;
    logic hit;

    reset_order_sync u_rst (
        .clock(clock),
        .global_reset_n(global_reset_n),
        .primary_bus_reset_n(primary_bus_reset_n),
        .core_resetn(core_resetn)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            lk1_q <= 1'b0;
            lk2_q <= 1'b0;
        end else begin
            lk1_q <= ~pri_lock_n;
            lk2_q <= lk1_q;
        end
    end

    // ------------------------------------------------------------
    // Routing field synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            route1_q <= ROUTE_RESET;
            route_q <= ROUTE_RESET;
        end else begin
            route1_q <= route_field;
            route_q <= route1_q;
        end
    end

    assign lock_in = lk2_q & resetn;
    assign hit = (block_of(pri_addr) == block_q);

    // ------------------------------------------------------------
    // Lock ownership state
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            state_q <= LK_IDLE;
            owner_q <= OWNER_RESET;
            block_q <= BLOCK_RESET;
        end else begin
            unique case (state_q)
                LK_IDLE: begin
                    // Only downstream accesses begun with lock deasserted arm ownership
                    if (pri_frame_start && pri_to_card && !lock_in) begin
                        state_q <= LK_ARMED;
                        owner_q <= pri_master_id;
                        block_q <= block_of(pri_addr);
                    end
                end
                LK_ARMED: begin
                    if (lock_in) begin
                        state_q <= LK_HELD;
                    end else if (pri_txn_end) begin
                        state_q <= LK_IDLE;
                        owner_q <= OWNER_RESET;
                    end
                end
                LK_HELD: begin
                    // Owner drops lock at end of final transaction
                    if (!lock_in && pri_txn_end && pri_master_id == owner_q) begin
                        state_q <= LK_IDLE;
                        owner_q <= OWNER_RESET;
                    end
                end
                default: state_q <= LK_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            card_lock_n_q <= 1'b1;
            mf4_q <= 1'b0;
            post_q <= 1'b1;
        end else begin
            card_lock_n_q <= ~(state_q == LK_HELD);
            mf4_q <= lock_in && (route_q == ROUTE_LOCK_SEL);
            post_q <= (state_q == LK_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Lock held flag
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            held_q <= 1'b0;
        end else begin
            held_q <= (state_q == LK_HELD);
        end
    end

    // ------------------------------------------------------------
    // Retry of other masters
    // ------------------------------------------------------------
    // Granted others to the locked block are retried; other blocks pass
    always_ff @(posedge clock or negedge core_resetn) begin
        if (!core_resetn) begin
            retry_q <= 1'b0;
        end else begin
            retry_q <= pri_frame_start && pri_grant && (state_q == LK_HELD)
                && hit && (pri_master_id != owner_q);
        end
    end

    assign card_lock_n = card_lock_n_q;
    assign multifunction_pin_four = mf4_q;
    assign post_enable = post_q;
    assign txn_retry = retry_q;
    assign lock_held = held_q;
    assign lock_owner = owner_q;

    // ------------------------------------------------------------
    // Ownership checks
    // ------------------------------------------------------------
    AST_MF4_ROUTE: assert property (@(posedge clock) disable iff (!core_resetn)
        mf4_q |-> $past(route_q) == ROUTE_LOCK_SEL) else $error("pin four without route");
    AST_MF4_LOCK: assert property (@(posedge clock) disable iff (!core_resetn)
        mf4_q |-> $past(lock_in)) else $error("pin four without lock");
    AST_NO_UPSTREAM: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_IDLE && !pri_to_card) |=> state_q == LK_IDLE)
        else $error("upstream lock taken");
    AST_OTHER_BLOCK: assert property (@(posedge clock) disable iff (!core_resetn)
        (pri_frame_start && !hit) |=> !retry_q) else $error("other block retried");
    AST_RETRY_LOCKED: assert property (@(posedge clock) disable iff (!core_resetn)
        (pri_frame_start && pri_grant && state_q == LK_HELD && hit
        && pri_master_id != owner_q) |=> retry_q) else $error("locked block not retried");
    AST_OWNER_PASS: assert property (@(posedge clock) disable iff (!core_resetn)
        (pri_frame_start && pri_master_id == owner_q) |=> !retry_q)
        else $error("owner retried");
    AST_NO_GRANT_OWN: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_ARMED && !lock_in) |=> state_q != LK_HELD)
        else $error("ownership without lock");
    AST_OWNER_STABLE: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_HELD && $past(state_q) == LK_HELD) |-> $stable(owner_q))
        else $error("owner changed while held");
    AST_ARM_OWNER: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_IDLE && pri_frame_start && pri_to_card && !lock_in)
        |=> (state_q == LK_ARMED && owner_q == $past(pri_master_id)))
        else $error("owner not recorded");

    // ------------------------------------------------------------
    // Output checks
    // ------------------------------------------------------------
    AST_NO_POST: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_HELD) |=> !post_q) else $error("posting during lock");
    AST_POST_ARMED: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_ARMED) |=> !post_q) else $error("posting while arming");
    AST_CARD_LOCK: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_HELD) |=> !card_lock_n_q) else $error("card lock missing");
    AST_CARD_FREE: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q != LK_HELD) |=> card_lock_n_q) else $error("card lock without hold");
    AST_RELEASE: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_HELD && !lock_in && pri_txn_end && pri_master_id == owner_q)
        |=> ##1 post_q) else $error("posting not resumed");
    AST_IDLE_NO_OWNER: assert property (@(posedge clock) disable iff (!core_resetn)
        (state_q == LK_IDLE) |-> owner_q == OWNER_RESET) else $error("stale owner in idle");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    COV_HELD: cover property (@(posedge clock) state_q == LK_HELD);
    COV_RETRY: cover property (@(posedge clock) retry_q);
    COV_RELEASE: cover property (@(posedge clock) state_q == LK_HELD ##1 state_q == LK_IDLE);
    COV_FALLBACK: cover property (@(posedge clock) state_q == LK_ARMED ##1 state_q == LK_IDLE);
    COV_PIN_FOUR: cover property (@(posedge clock) mf4_q);
endmodule : lock_bridge
`default_nettype wire

// File: test/lock_partner.sv
// Full-lock arbiter and reset source for the primary side
`timescale 1ns/1ps
`default_nettype none
module lock_partner #(parameter int STABLE_CYC = 25000) ( // 100 us of 4 ns cycles
    // Clock and lock state
    input wire logic clock,
    input wire logic full_lock,
    input wire logic snoop_wb,
    input wire logic lock_held,
    input wire logic [lock_bridge_pkg::MASTER_W-1:0] lock_owner,
    input wire logic [lock_bridge_pkg::MASTER_W-1:0] req_id,
    // Grant and resets
    output logic grant,
    output logic global_reset_n,
    output logic primary_bus_reset_n
);
    int cyc = 0;
    // Both resets low from power-up; bus reset follows global reset
    always @(negedge clock) begin
        cyc <= cyc + 1;
    end
    assign global_reset_n = (cyc > STABLE_CYC);
    assign primary_bus_reset_n = (cyc > STABLE_CYC + 1);
    assign grant = !full_lock || !lock_held || req_id == lock_owner || snoop_wb;
endmodule : lock_partner
`default_nettype wire

// File: test/lock_bridge_tb.sv
// Self-checking bench for the exclusive access bridge
`timescale 1ns/1ps
`default_nettype none
module lock_bridge_tb;
    import lock_bridge_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic gr_n, pr_n, grant, full_lock = 1'b0, snoop_wb = 1'b0;
    logic [ROUTE_W-1:0] route_field = 4'h0;
    logic lock_n = 1'b1, start = 1'b0, t_end = 1'b0, to_card = 1'b0;
    logic [MASTER_W-1:0] mid = 4'h0, owner, id;
    logic [ADDR_W-1:0] addr = 32'h0, a;
    logic card_lock_n, pin4, post_en, retry, held, m_held;
    int num_errors = 0, tests_run = 0, cycles = 0, m_owner, m_block, m_retries;
    always #2 clock = ~clock;
    lock_bridge dut_u (.clock(clock), .resetn(resetn), .global_reset_n(gr_n),
        .primary_bus_reset_n(pr_n), .route_field(route_field), .pri_lock_n(lock_n),
        .pri_frame_start(start), .pri_txn_end(t_end), .pri_master_id(mid),
        .pri_addr(addr), .pri_to_card(to_card), .pri_grant(grant),
        .card_lock_n(card_lock_n), .multifunction_pin_four(pin4),
        .post_enable(post_en), .txn_retry(retry), .lock_held(held), .lock_owner(owner));
    lock_partner part_u (.clock(clock), .full_lock(full_lock), .snoop_wb(snoop_wb),
        .lock_held(held), .lock_owner(owner), .req_id(mid), .grant(grant),
        .global_reset_n(gr_n), .primary_bus_reset_n(pr_n));
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (retry === 1'b1) m_retries = m_retries + 1;
        if (cycles == 30000) begin
            num_errors = num_errors + 1;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (exp !== got) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic cmp_all();
        chk("held", m_held, held);
        chk("card_lock_n", !m_held, card_lock_n);
        chk("post_enable", !m_held, post_en);
        chk("owner", m_held ? m_owner : 0, owner);
        chk("pin_four", !lock_n && route_field == ROUTE_LOCK_SEL, pin4);
    endtask : cmp_all
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic begin_txn(input logic [3:0] i, input logic [31:0] ad, input logic dn);
        mid = i;
        addr = ad;
        to_card = dn;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
    endtask : begin_txn
    task automatic probe(input logic [3:0] i, input logic [31:0] ad);
        logic exp;
        exp = i != m_owner && ad[31:4] == m_block && (!full_lock || snoop_wb);
        m_retries = 0;
        begin_txn(i, ad, 1'b1);
        cyc(2);
        chk("retry", exp, m_retries != 0);
        cmp_all();
    endtask : probe
    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        void'($urandom(32'h4BF7));
        m_held = 0;
        m_owner = 0;
        cyc(6);
        resetn = 1'b1;
        cmp_all();
        wait (pr_n === 1'b1);
        cyc(6);
        $display("reset test done");
        route_field = ROUTE_LOCK_SEL;
        begin_txn(4'($urandom), $urandom, 1'b0);
        lock_n = 1'b0;
        cyc(8);
        cmp_all();
        lock_n = 1'b1;
        cyc(4);
        t_end = 1'b1;
        cyc(1);
        t_end = 1'b0;
        $display("upstream test done");
        begin_txn(4'($urandom), $urandom, 1'b1);
        t_end = 1'b1;
        cyc(1);
        t_end = 1'b0;
        cyc(3);
        cmp_all();
        $display("grant only test done");
        repeat (4) begin
            id = 4'($urandom);
            a = $urandom;
            route_field = 4'($urandom);
            begin_txn(id, a, 1'b1);
            lock_n = 1'b0;
            repeat (10) if (held !== 1'b1) cyc(1);
            cyc(1);
            m_held = 1;
            m_owner = id;
            m_block = a[31:4];
            cmp_all();
            for (int r = 0; r < 16; r++) begin
                route_field = 4'(r);
                cyc(3);
                chk("pin_four", r == 4, pin4);
            end
            probe(id + 4'(1 + $urandom % 15), a ^ 32'($urandom % 16));
            probe(id + 4'h1, a + 32'h10);
            probe(id, a);
            full_lock = 1'b1;
            probe(id + 4'h2, a);
            snoop_wb = 1'b1;
            probe(id + 4'h3, a);
            full_lock = 1'b0;
            snoop_wb = 1'b0;
            lock_n = 1'b1;
            cyc(4);
            mid = id;
            t_end = 1'b1;
            cyc(1);
            t_end = 1'b0;
            cyc(3);
            m_held = 0;
            cmp_all();
            $display("lock test done");
        end
        give_verdict();
    end
endmodule : lock_bridge_tb
`default_nettype wire
